// >>> hw/wdu_consts.vh
// Constants for the watchdog timer unit
`ifndef WDU_CONSTS_VH
`define WDU_CONSTS_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define WDU_ADDR_CTRL      12'h000
`define WDU_ADDR_STATUS    12'h004
`define WDU_ADDR_VECTOR    12'h008
// ****************************************
// Control register fields
// ****************************************
`define WDU_BIT_SRC2       5
`define WDU_BIT_STPRST     6
`define WDU_BIT_SRC        7
`define WDU_CTRL_RESET     8'h00
`define WDU_CNT_LOAD       8'hff
// ****************************************
// Status register fields
// ****************************************
`define WDU_ST_RUN         0
`define WDU_ST_LOCKED      1
`define WDU_ST_STOPMODE    2
`define WDU_ST_RSTCAUSE    3
`define WDU_ST_INTRST      4
// ****************************************
// Prescaler and timing
// ****************************************
`define WDU_PRE_BITS       10
`define WDU_PRE_BITS_FAST  3
`define WDU_RST_HOLD_NS    2000
`define WDU_CLK_NS         25
`define WDU_RST_HOLD_CYC   ((`WDU_RST_HOLD_NS + `WDU_CLK_NS - 1) / `WDU_CLK_NS)
// ****************************************
// Reset vector locations
// ****************************************
`define WDU_VEC_LO         16'hfffc
`define WDU_VEC_HI         16'hfffd
`endif

// >>> hw/wdu_sync.v
// Two-stage synchroniser for asynchronous level inputs
`default_nettype none
module wdu_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
        end
    end
    assign q = s2_reg;
endmodule // wdu_sync
`default_nettype wire

// >>> hw/wdu_edge.v
// Rising-edge detector producing a one-cycle enable pulse
`default_nettype none
module wdu_edge (
    input  wire pclk,
    input  wire presetn,
    input  wire d,
    output wire pulse
);
    reg last_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= d;
        end
    end
    assign pulse = d & ~last_reg;
endmodule // wdu_edge
`default_nettype wire

// >>> hw/wdu_watchdog.v
// Watchdog timer unit with APB register access
// Notes on behaviour
// - Supervision counter is eight bits, counting down; underflow is timeout.
// - Reset and every control write load the counter with all ones.
// - Bits seven and five writable once after reset, bit six can be set by any later write; read zero after reset.
// - Counter idle after reset until first control write.
// - Underflow asserts internal reset; restart from reset vector after release.
// - After reset, start address fetched high from FFFD, low from FFFC.
// - Read gives upper five counter bits low, sources bits 5/7, stop bit 6.
// - Stop bit clear: stop instruction enters stop mode; counting resumes after.
// - Idle instruction never halts the counter.
// - Stop bit set: stop instruction causes internal reset.
// - Stop bit sticks at one once set; zero after reset.
// - Bit seven clear: timeout is 2^18 source cycles (32.768 ms at 8 MHz).
// - Counter keeps counting during stop-release stabilisation wait and wait mode.
// - On-chip oscillator source forces that oscillator running.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`default_nettype none
`include "wdu_consts.vh"
module wdu_watchdog #(
    parameter PRE_BITS      = `WDU_PRE_BITS,
    parameter PRE_BITS_FAST = `WDU_PRE_BITS_FAST,
    parameter RST_HOLD      = `WDU_RST_HOLD_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        main_osc_input,
    input  wire        sub_osc_input,
    input  wire        onchip_osc_input,
    input  wire        halt_instruction,
    input  wire        idle_instruction,
    input  wire        stop_release,
    input  wire        stab_wait_done,
    output reg         internal_reset,
    output reg         stop_mode,
    output wire        onchip_osc_force_on,
    output reg         vector_fetch,
    output wire [15:0] vector_addr_hi,
    output wire [15:0] vector_addr_lo
);
    // ****************************************
    // Clock source inputs
    // ****************************************
    wire [2:0] osc_sync;
    wire       main_tick;
    wire       sub_tick;
    wire       onchip_tick;
    wdu_sync #(.W(3)) u_osc_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({onchip_osc_input, sub_osc_input, main_osc_input}),
        .q       (osc_sync)
    );
    wdu_edge u_edge_main (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (osc_sync[0]),
        .pulse   (main_tick)
    );
    wdu_edge u_edge_sub (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (osc_sync[1]),
        .pulse   (sub_tick)
    );
    wdu_edge u_edge_onchip (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (osc_sync[2]),
        .pulse   (onchip_tick)
    );
    // ****************************************
    // Register state
    // ****************************************
    reg  [7:0]          cnt_reg;
    reg  [PRE_BITS-1:0] pre_reg;
    reg                 run_reg;
    reg                 locked_reg;
    reg                 src_reg;
    reg                 src2_reg;
    reg                 stprst_reg;
    reg                 cause_reg;
    reg  [15:0]         hold_reg;
    wire                wr_en;
    wire                rd_en;
    wire                ctrl_wr;
    wire                src_tick;
    wire                pre_wrap;
    wire                cnt_tick;
    wire                underflow;
    wire                stop_reset;
    wire                trigger;
    // Hold count sized on purpose for the 16-bit down counter
    localparam [15:0]   RST_HOLD_W = RST_HOLD;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign ctrl_wr = wr_en & (paddr == `WDU_ADDR_CTRL);
    // Bit 5 picks on-chip oscillator; otherwise main clock
    assign src_tick = src2_reg ? onchip_tick : main_tick;
    assign onchip_osc_force_on = src2_reg;
    // Bit 7 set shortens the prescaler; bit 7 clear gives 2^18 total
    assign pre_wrap = src_reg ? (pre_reg[PRE_BITS_FAST-1:0] == {PRE_BITS_FAST{1'b1}})
                              : (pre_reg == {PRE_BITS{1'b1}});
    // Counting continues in wait and stabilisation, only true stop halts
    assign cnt_tick  = run_reg & ~stop_mode & src_tick & pre_wrap;
    assign underflow = cnt_tick & (cnt_reg == 8'h00);
    assign stop_reset = halt_instruction & stprst_reg;
    assign trigger   = (underflow | stop_reset) & ~internal_reset;
    // ****************************************
    // Counter and control
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg    <= `WDU_CNT_LOAD;
            pre_reg    <= {PRE_BITS{1'b0}};
            run_reg    <= 1'b0;
            locked_reg <= 1'b0;
            src_reg    <= 1'b0;
            src2_reg   <= 1'b0;
            stprst_reg <= 1'b0;
            cause_reg  <= 1'b0;
        end else if (internal_reset) begin
            // Internal reset returns the unit to its idle state
            cnt_reg    <= `WDU_CNT_LOAD;
            pre_reg    <= {PRE_BITS{1'b0}};
            run_reg    <= 1'b0;
            locked_reg <= 1'b0;
            src_reg    <= 1'b0;
            src2_reg   <= 1'b0;
            stprst_reg <= 1'b0;
        end else begin
            if (trigger) begin
                cause_reg <= stop_reset;
            end
            if (ctrl_wr) begin
                cnt_reg <= `WDU_CNT_LOAD;
                pre_reg <= {PRE_BITS{1'b0}};
                run_reg <= 1'b1;
                if (!locked_reg) begin
                    locked_reg <= 1'b1;
                    src_reg    <= pwdata[`WDU_BIT_SRC];
                    src2_reg   <= pwdata[`WDU_BIT_SRC2];
                end
                // Sticky once set, clearing attempts ignored
                stprst_reg <= stprst_reg | pwdata[`WDU_BIT_STPRST];
            end else if (run_reg && !stop_mode && src_tick) begin
                pre_reg <= pre_reg + {{(PRE_BITS-1){1'b0}}, 1'b1};
                if (cnt_tick) begin
                    cnt_reg <= cnt_reg - 8'h01;
                end
            end
        end
    end
    // ****************************************
    // Stop mode and internal reset
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_mode      <= 1'b0;
            internal_reset <= 1'b0;
            hold_reg       <= 16'h0000;
            vector_fetch   <= 1'b0;
        end else begin
            vector_fetch <= 1'b0;
            if (trigger) begin
                internal_reset <= 1'b1;
                stop_mode      <= 1'b0;
                hold_reg       <= RST_HOLD_W;
            end else if (internal_reset) begin
                if (hold_reg <= 16'h0001) begin
                    internal_reset <= 1'b0;
                    vector_fetch   <= 1'b1;
                end
                hold_reg <= hold_reg - 16'h0001;
            end else if (halt_instruction && !stprst_reg) begin
                stop_mode <= 1'b1;
            end else if (stop_release) begin
                // Counting resumes at once, through the stabilisation wait
                stop_mode <= 1'b0;
            end
        end
    end
    assign vector_addr_hi = `WDU_VEC_HI;
    assign vector_addr_lo = `WDU_VEC_LO;
    // ****************************************
    // APB read path
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            if (paddr == `WDU_ADDR_CTRL) begin
                prdata <= {24'h000000, src_reg, stprst_reg, src2_reg, cnt_reg[7:3]};
            end else if (paddr == `WDU_ADDR_STATUS) begin
                prdata <= {27'h0000000, internal_reset, cause_reg, stop_mode,
                           locked_reg, run_reg};
            end else if (paddr == `WDU_ADDR_VECTOR) begin
                prdata <= {`WDU_VEC_HI, `WDU_VEC_LO};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
    // stab_wait_done is informational: counting never pauses for it
    wire unused_ok = stab_wait_done & idle_instruction;
endmodule // wdu_watchdog
`default_nettype wire

// >>> verif/wdu_watchdog_asserts.sv
// Port-level checks for the watchdog timer unit
`default_nettype none
module wdu_watchdog_asserts #(
    parameter RST_HOLD = 4
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        halt_instruction,
    input wire logic        stop_release,
    input wire logic        internal_reset,
    input wire logic        stop_mode,
    input wire logic        onchip_osc_force_on,
    input wire logic        vector_fetch,
    input wire logic [15:0] vector_addr_hi,
    input wire logic [15:0] vector_addr_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Helper state and assertions
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       wr_ctrl;
    logic       written_reg;
    logic       stp_reg;
    logic [7:0] hold_reg;
    // Writes during internal reset are dropped, so they do not count
    assign wr_ctrl = psel && penable && pwrite && pready && paddr == 12'h000 && !internal_reset;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            written_reg <= 1'b0;
            stp_reg     <= 1'b0;
            hold_reg    <= 8'h00;
        end else begin
            written_reg <= written_reg | wr_ctrl;
            stp_reg     <= internal_reset ? 1'b0 : (stp_reg | (wr_ctrl & pwdata[6]));
            hold_reg    <= internal_reset ? hold_reg + 8'h01 : 8'h00;
        end
    end
    sequence s_rst_end;
        $fell(internal_reset);
    endsequence
    sequence s_halt_seen;
        halt_instruction && !stop_mode && !internal_reset;
    endsequence
    chk_rst_length: assert property (s_rst_end |-> hold_reg == RST_HOLD)
        else $error("internal reset length wrong");
    chk_vec_fetch: assert property (s_rst_end |-> ##[0:2] vector_fetch)
        else $error("no vector fetch after internal reset");
    chk_vec_pulse: assert property (vector_fetch |=> !vector_fetch)
        else $error("vector fetch longer than one cycle");
    chk_vec_addr: assert property (vector_addr_hi == 16'hfffd && vector_addr_lo == 16'hfffc)
        else $error("vector locations wrong");
    chk_idle_quiet: assert property (!written_reg |-> !internal_reset && !onchip_osc_force_on)
        else $error("unit active before first write");
    chk_force_first: assert property (wr_ctrl && !written_reg |=> onchip_osc_force_on == $past(pwdata[5]))
        else $error("oscillator force does not follow first write");
    chk_force_hold: assert property (onchip_osc_force_on && !internal_reset |=> onchip_osc_force_on || internal_reset)
        else $error("oscillator force dropped");
    chk_halt_stop: assert property (s_halt_seen and !stp_reg |-> ##[1:4] stop_mode && !internal_reset)
        else $error("halt did not enter stop mode");
    chk_halt_reset: assert property (s_halt_seen and stp_reg |-> ##[1:4] internal_reset && !stop_mode)
        else $error("halt did not cause internal reset");
    chk_stop_exit: assert property (stop_mode && stop_release |-> ##[1:4] !stop_mode)
        else $error("stop mode not left");
endmodule // wdu_watchdog_asserts
bind wdu_watchdog wdu_watchdog_asserts #(.RST_HOLD(RST_HOLD)) i_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .halt_instruction,
    .stop_release, .internal_reset, .stop_mode, .onchip_osc_force_on, .vector_fetch,
    .vector_addr_hi, .vector_addr_lo
);
`default_nettype wire

// >>> verif/tb_watchdog_timer_unit.sv
// Self-checking testbench for the watchdog timer unit
`default_nettype none
module tb_watchdog_timer_unit;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Stimulus, tasks and scenarios
    // ****************************************
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        halt_instruction = 1'b0;
    logic        idle_instruction = 1'b0;
    logic        stop_release = 1'b0;
    logic [3:0]  div = 4'h0;
    wire         pready;
    wire  [31:0] prdata;
    wire         internal_reset;
    wire         stop_mode;
    wire         onchip_osc_force_on;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          n;
    always #12.5 pclk = ~pclk;
    // Source clocks slower than 4 pclk so the synchroniser sees every edge
    always @(posedge pclk) div <= div + 4'h1;
    wdu_watchdog #(.PRE_BITS(2), .PRE_BITS_FAST(1), .RST_HOLD(4)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr(), .main_osc_input(div[2]), .sub_osc_input(div[2]),
        .onchip_osc_input(div[3]), .halt_instruction, .idle_instruction, .stop_release,
        .stab_wait_done(1'b0), .internal_reset, .stop_mode, .onchip_osc_force_on,
        .vector_fetch(), .vector_addr_hi(), .vector_addr_lo()
    );
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_rng(input int got, input int exp, input int tol);
        total_checks++;
        if (got < exp - tol || got > exp + tol) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %0d cycles, expected %0d", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        int i;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 100);
        if (!wr) chk(prdata, e);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rst();
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task wait_rst();
        n = 0;
        while (internal_reset !== 1'b1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task final_report();
        $display("Checks: %0d, mismatches: %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (70000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end
    initial begin
        rst();
        apb(0, 12'h000, 0, 32'h1f);
        apb(0, 12'h004, 0, 32'h0);
        apb(0, 12'h008, 0, 32'hfffdfffc);
        apb(0, 12'h00c, 0, 32'h0);
        repeat (300) @(posedge pclk);
        apb(0, 12'h000, 0, 32'h1f);
        apb(1, 12'h000, 32'h0, 0);
        idle_instruction <= 1'b1;
        @(posedge pclk);
        idle_instruction <= 1'b0;
        repeat (4000) @(posedge pclk);
        apb(1, 12'h000, 32'h0, 0);
        wait_rst();
        chk_rng(n, 8192, 16);
        rst();
        apb(1, 12'h000, 32'h80, 0);
        apb(1, 12'h000, 32'h20, 0);
        apb(0, 12'h000, 0, 32'h9f);
        // Let the launching edge settle before looking
        @(negedge pclk);
        chk({31'h0, onchip_osc_force_on}, 32'h0);
        wait_rst();
        chk_rng(n, 4096, 16);
        rst();
        apb(1, 12'h000, 32'h20, 0);
        @(negedge pclk);
        chk({31'h0, onchip_osc_force_on}, 32'h1);
        wait_rst();
        chk_rng(n, 16384, 32);
        rst();
        apb(1, 12'h000, 32'h40, 0);
        apb(1, 12'h000, 32'h0, 0);
        apb(0, 12'h000, 0, 32'h5f);
        halt_instruction <= 1'b1;
        @(posedge pclk);
        halt_instruction <= 1'b0;
        wait_rst();
        chk_rng(n, 3, 3);
        chk({31'h0, stop_mode}, 32'h0);
        rst();
        apb(1, 12'h000, 32'h0, 0);
        halt_instruction <= 1'b1;
        @(posedge pclk);
        halt_instruction <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(0, 12'h004, 0, 32'h7);
        stop_release <= 1'b1;
        @(posedge pclk);
        stop_release <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(0, 12'h004, 0, 32'h3);
        wait_rst();
        chk_rng(n, 8180, 40);
        final_report();
    end
endmodule // tb_watchdog_timer_unit
`default_nettype wire
